/* File: hdl/pmgpe_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pmgpe_edge_sync #(
   parameter int W = 5
) (
   input  wire logic         i_clock,
   input  wire logic         i_rst,
   input  wire logic [W-1:0] i_level,
   output logic      [W-1:0] o_change
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] prev;
      logic [1:0]   warm;
   } pmgpe_edge_t;

   pmgpe_edge_t st_r;
   pmgpe_edge_t st_nxt;

   generate
      if (W < 1) begin : g_bad_width
         $error("pmgpe_edge_sync: W must be at least 1");
      end
   endgenerate

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = i_level;
      st_nxt.sync = st_r.meta;
      st_nxt.prev = st_r.sync;
      if (st_r.warm != 2'h3) begin
         st_nxt.warm = st_r.warm + 2'h1;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Held off until the chain holds real samples, so reset gives no false edge
   assign o_change = (st_r.warm == 2'h3) ? (st_r.sync ^ st_r.prev) : '0;
endmodule : pmgpe_edge_sync
`default_nettype wire

/* File: hdl/pmgpe_regs_top.sv */
//
// Behaviour
// - Bridge extension bit 7 always reads one; writes ignored.
// - Bridge extension bit 6 is read-only zero.
// - Bridge extension bits 5..0 are reserved, read-only zero.
// - Power-management data byte reads zero in both functions.
// - Writing one clears a status bit and its event; zero leaves it.
// - Status bits latch events regardless of enable bits.
// - Event status register exists only in function 0.
// - Bit 15 sets when socket 0 video enable changes.
// - Bit 14 sets when socket 1 video enable changes.
// - Bit 11 sets on any supply or Vpp change of either socket.
// - Bit 8 sets when either Vpp request moves to or from 12 V.
// - Bits 4..0 set on level change of their terminal input.
// - Reserved status bits 13-12, 10-9, 7-5 read zero.
// - Enabled event output stays until its status bit is cleared.
// - Event reaches a terminal only where configured for event signalling.
`timescale 1ns/1ps
`default_nettype none
`include "pmgpe_regs.svh"
module pmgpe_regs_top #(
   parameter int GPI_WIDTH = 5
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_cfg_valid,
   input  wire logic        i_cfg_write,
   input  wire logic        i_cfg_func,
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic [3:0]  i_cfg_be,
   input  wire logic [31:0] i_cfg_wdata,
   output logic             o_cfg_ack,
   output logic      [31:0] o_cfg_rdata,
   input  wire logic [4:0]  i_gpi_level,
   input  wire logic        i_zoomed_video_enable0,
   input  wire logic        i_zoomed_video_enable1,
   input  wire logic [1:0]  i_socket0_vcc,
   input  wire logic [1:0]  i_socket1_vcc,
   input  wire logic [1:0]  i_socket0_vpp,
   input  wire logic [1:0]  i_socket1_vpp,
   input  wire logic [15:0] i_event_enable,
   input  wire logic [6:0]  i_multifunction_terminal_event_sel,
   output logic             o_general_event_output,
   output logic      [15:0] o_general_event_status,
   output logic      [6:0]  o_multifunction_terminal_event
);
   pmgpe_pkg::pmgpe_state_t st_r;
   pmgpe_pkg::pmgpe_state_t st_nxt;

   logic [4:0]  gpi_change;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic        sts_write;
   logic        pwr_change;
   logic        vpp12_change;

   generate
      if (GPI_WIDTH != 5) begin : g_bad_gpi
         $error("pmgpe_regs_top: GPI_WIDTH must be 5");
      end
   endgenerate

   // Bit 4 follows terminal 5, bit 3 terminal 4, bits 2..0 terminals 2..0
   pmgpe_edge_sync #(
      .W (GPI_WIDTH)
   ) i_pmgpe_edge_sync (
      .i_clock  (i_clock),
      .i_rst    (i_rst),
      .i_level  (i_gpi_level),
      .o_change (gpi_change)
   );

   always_comb begin
      pwr_change   = st_r.primed &&
                     ((i_socket0_vcc != st_r.vcc0_prev) || (i_socket1_vcc != st_r.vcc1_prev) ||
                      (i_socket0_vpp != st_r.vpp0_prev) || (i_socket1_vpp != st_r.vpp1_prev));
      vpp12_change = st_r.primed &&
                     (((i_socket0_vpp == `PMGPE_VPP_12V) != (st_r.vpp0_prev == `PMGPE_VPP_12V)) ||
                      ((i_socket1_vpp == `PMGPE_VPP_12V) != (st_r.vpp1_prev == `PMGPE_VPP_12V)));
      set_vec = '0;
      set_vec[`PMGPE_STS_ZV0]   = st_r.primed && (i_zoomed_video_enable0 != st_r.zv_prev[0]);
      set_vec[`PMGPE_STS_ZV1]   = st_r.primed && (i_zoomed_video_enable1 != st_r.zv_prev[1]);
      set_vec[`PMGPE_STS_PWR]   = pwr_change;
      set_vec[`PMGPE_STS_VPP12] = vpp12_change;
      set_vec[`PMGPE_STS_GPI_MSB:0] = gpi_change;
   end

   // Function 1 has no event status register
   assign sts_write = i_cfg_valid && i_cfg_write && (i_cfg_func == 1'b0) &&
                      (i_cfg_addr[7:2] == `PMGPE_DW_EVENT >> 2);

   always_comb begin
      clr_vec = '0;
      if (sts_write) begin
         clr_vec[7:0]  = i_cfg_be[0] ? i_cfg_wdata[7:0] : 8'h00;
         clr_vec[15:8] = i_cfg_be[1] ? i_cfg_wdata[15:8] : 8'h00;
      end
   end

   always_comb begin
      st_nxt           = st_r;
      st_nxt.primed    = 1'b1;
      st_nxt.zv_prev   = {i_zoomed_video_enable1, i_zoomed_video_enable0};
      st_nxt.vcc0_prev = i_socket0_vcc;
      st_nxt.vcc1_prev = i_socket1_vcc;
      st_nxt.vpp0_prev = i_socket0_vpp;
      st_nxt.vpp1_prev = i_socket1_vpp;
      // Set is ORed in after the clear so a same-cycle event survives
      st_nxt.sts = ((st_r.sts & ~clr_vec) | set_vec) & `PMGPE_STS_MASK;
      st_nxt.evt = |(st_nxt.sts & i_event_enable);
      st_nxt.ack   = i_cfg_valid;
      st_nxt.rdata = 32'h0000_0000;
      if (i_cfg_valid && !i_cfg_write) begin
         if (i_cfg_addr[7:2] == `PMGPE_DW_PMCSR >> 2) begin
            st_nxt.rdata[`PMGPE_BSE_LSB +: 8]  = `PMGPE_BSE_VALUE;
            st_nxt.rdata[`PMGPE_DATA_LSB +: 8] = `PMGPE_DATA_VALUE;
         end else if ((i_cfg_addr[7:2] == `PMGPE_DW_EVENT >> 2) && (i_cfg_func == 1'b0)) begin
            st_nxt.rdata[`PMGPE_STS_LSB +: 16] = st_r.sts;
         end
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         st_r     <= '0;
         st_r.sts <= `PMGPE_STS_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_cfg_ack              = st_r.ack;
   assign o_cfg_rdata            = st_r.rdata;
   assign o_general_event_output = st_r.evt;
   assign o_general_event_status = st_r.sts;
   assign o_multifunction_terminal_event = {7{st_r.evt}} & i_multifunction_terminal_event_sel;

   property p_bse_bit7;
      @(posedge i_clock) disable iff (i_rst)
         (i_cfg_valid && !i_cfg_write && i_cfg_addr == `PMGPE_OFF_BSE) |=>
            (o_cfg_ack && o_cfg_rdata[`PMGPE_BSE_LSB + `PMGPE_BSE_BPCC] == 1'b1);
   endproperty
   a_bse_bit7: assert property (p_bse_bit7) else $error("bus power control bit not one");

   property p_bse_bit6;
      @(posedge i_clock) disable iff (i_rst)
         (i_cfg_valid && !i_cfg_write && i_cfg_addr[7:2] == `PMGPE_DW_PMCSR >> 2) |=>
            (o_cfg_rdata[`PMGPE_BSE_LSB + `PMGPE_BSE_B2B3] == 1'b0);
   endproperty
   a_bse_bit6: assert property (p_bse_bit6) else $error("hot state support bit not zero");

   property p_bse_rsvd;
      @(posedge i_clock) disable iff (i_rst)
         (i_cfg_valid && !i_cfg_write && i_cfg_addr[7:2] == `PMGPE_DW_PMCSR >> 2) |=>
            (o_cfg_rdata[`PMGPE_BSE_LSB +: 6] == 6'h00);
   endproperty
   a_bse_rsvd: assert property (p_bse_rsvd) else $error("extension reserved bits not zero");

   property p_data_zero;
      @(posedge i_clock) disable iff (i_rst)
         (i_cfg_valid && i_cfg_addr[7:2] == `PMGPE_DW_PMCSR >> 2) |=>
            (o_cfg_rdata[`PMGPE_DATA_LSB +: 8] == 8'h00);
   endproperty
   a_data_zero: assert property (p_data_zero) else $error("data byte not zero");

   property p_clear_one;
      @(posedge i_clock) disable iff (i_rst)
         (sts_write && i_cfg_be[0] && i_cfg_wdata[0] && !gpi_change[0]) |=>
            (o_general_event_status[0] == 1'b0);
   endproperty
   a_clear_one: assert property (p_clear_one) else $error("write one did not clear");

   property p_keep_zero;
      @(posedge i_clock) disable iff (i_rst)
         (sts_write && i_cfg_be[1] && !i_cfg_wdata[`PMGPE_STS_ZV0] && o_general_event_status[15]) |=>
            o_general_event_status[15];
   endproperty
   a_keep_zero: assert property (p_keep_zero) else $error("write zero cleared a bit");

   property p_set_no_enable;
      @(posedge i_clock) disable iff (i_rst)
         (gpi_change[3] && !i_event_enable[3]) |=> o_general_event_status[3];
   endproperty
   a_set_no_enable: assert property (p_set_no_enable) else $error("event lost when disabled");

   property p_func1_zero;
      @(posedge i_clock) disable iff (i_rst)
         (i_cfg_valid && !i_cfg_write && i_cfg_func && i_cfg_addr[7:2] == `PMGPE_DW_EVENT >> 2)
            |=> (o_cfg_ack && o_cfg_rdata == 32'h0000_0000);
   endproperty
   a_func1_zero: assert property (p_func1_zero) else $error("function 1 sees status");

   property p_zv0;
      @(posedge i_clock) disable iff (i_rst)
         (st_r.primed && $changed(i_zoomed_video_enable0)) |=> o_general_event_status[15];
   endproperty
   a_zv0: assert property (p_zv0) else $error("video enable change missed");

   property p_rsvd_zero;
      @(posedge i_clock) disable iff (i_rst)
         ((o_general_event_status & ~`PMGPE_STS_MASK) == 16'h0000);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved status bit set");

   property p_hold_event;
      @(posedge i_clock) disable iff (i_rst)
         (o_general_event_output && !sts_write && $stable(i_event_enable)) |=>
            o_general_event_output;
   endproperty
   a_hold_event: assert property (p_hold_event) else $error("event dropped without clear");

   property p_pin_gate;
      @(posedge i_clock) disable iff (i_rst)
         ((o_multifunction_terminal_event & ~i_multifunction_terminal_event_sel) == 7'h00);
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("event on unselected terminal");

   property p_set_wins;
      @(posedge i_clock) disable iff (i_rst)
         (sts_write && i_cfg_be[0] && i_cfg_wdata[1] && gpi_change[1]) |=>
            o_general_event_status[1];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");
endmodule : pmgpe_regs_top
`default_nettype wire

/* File: shared/pmgpe_pkg.sv */
package pmgpe_pkg;

   typedef enum logic {
      PMGPE_FUNC0,
      PMGPE_FUNC1
   } pmgpe_func_t;

   typedef struct packed {
      logic [15:0] sts;
      logic [1:0]  zv_prev;
      logic [1:0]  vcc0_prev;
      logic [1:0]  vcc1_prev;
      logic [1:0]  vpp0_prev;
      logic [1:0]  vpp1_prev;
      logic        primed;
      logic        ack;
      logic [31:0] rdata;
      logic        evt;
   } pmgpe_state_t;

endpackage : pmgpe_pkg

/* File: shared/pmgpe_regs.svh */
`ifndef PMGPE_REGS_SVH
`define PMGPE_REGS_SVH

// Dword-aligned configuration addresses
`define PMGPE_DW_PMCSR      8'ha4
`define PMGPE_DW_EVENT      8'ha8
// Byte offsets as mapped
`define PMGPE_OFF_BSE       8'ha6
`define PMGPE_OFF_DATA      8'ha7
`define PMGPE_OFF_STS       8'ha8
// Lane positions inside the dwords
`define PMGPE_BSE_LSB       16
`define PMGPE_DATA_LSB      24
`define PMGPE_STS_LSB       0
// Field positions of the event status and bridge extension registers
`define PMGPE_STS_ZV0       15
`define PMGPE_STS_ZV1       14
`define PMGPE_STS_PWR       11
`define PMGPE_STS_VPP12     8
`define PMGPE_STS_GPI_MSB   4
`define PMGPE_BSE_BPCC      7
`define PMGPE_BSE_B2B3      6
// Reset and constant values
`define PMGPE_BSE_VALUE     8'h80
`define PMGPE_DATA_VALUE    8'h00
`define PMGPE_STS_RESET     16'h0000
`define PMGPE_STS_MASK      16'hc91f
// Vpp request code meaning 12 V
`define PMGPE_VPP_12V       2'h2

`endif

/* File: tb/pmgpe_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmgpe_host_model (
   input  wire logic        i_clock,
   output logic             o_cfg_valid,
   output logic             o_cfg_write,
   output logic             o_cfg_func,
   output logic      [7:0]  o_cfg_addr,
   output logic      [3:0]  o_cfg_be,
   output logic      [31:0] o_cfg_wdata
);
   initial begin
      o_cfg_valid = 1'b0;
      o_cfg_write = 1'b0;
      o_cfg_func  = 1'b0;
      o_cfg_addr  = 8'h00;
      o_cfg_be    = 4'h0;
      o_cfg_wdata = 32'h0000_0000;
   end
   // Event register is only meant for function 0; bench asks for function 1 on purpose
   task automatic cfg(input logic wr, input logic fn, input logic [7:0] ad,
                      input logic [3:0] be, input logic [31:0] wd, input int gap);
      repeat (gap) @(posedge i_clock);
      @(posedge i_clock);
      o_cfg_valid <= 1'b1;
      o_cfg_write <= wr;
      o_cfg_func  <= fn;
      o_cfg_addr  <= ad;
      o_cfg_be    <= be;
      o_cfg_wdata <= wd;
      @(posedge i_clock);
      // Released lines show garbage, not stale values
      o_cfg_valid <= 1'b0;
      o_cfg_write <= ~wr;
      o_cfg_func  <= ~fn;
      o_cfg_addr  <= ~ad;
      o_cfg_be    <= ~be;
      o_cfg_wdata <= ~wd;
   endtask : cfg
endmodule : pmgpe_host_model
`default_nettype wire

/* File: tb/pmgpe_regs_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module pmgpe_regs_top_bench;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        cv, cw, cf, ack, evt;
   logic [7:0]  ca;
   logic [3:0]  cb;
   logic [31:0] cd, rdat;
   logic [4:0]  gpi = 5'h00;
   logic        zv0 = 1'b0, zv1 = 1'b0;
   logic [1:0]  vcc0 = 2'h0, vcc1 = 2'h0, vpp0 = 2'h0, vpp1 = 2'h0;
   logic [15:0] en = 16'h0000, sts;
   logic [6:0]  sel = 7'h00, term;
   logic [31:0] seed = 32'ha3b36e44;
   logic [31:0] q[$];
   int          miscompares = 0, checked = 0;
   pmgpe_host_model i_pmgpe_host_model (.i_clock(i_clock), .o_cfg_valid(cv), .o_cfg_write(cw),
      .o_cfg_func(cf), .o_cfg_addr(ca), .o_cfg_be(cb), .o_cfg_wdata(cd));
   pmgpe_regs_top i_pmgpe_regs_top (.i_clock(i_clock), .i_rst(i_rst), .i_cfg_valid(cv),
      .i_cfg_write(cw), .i_cfg_func(cf), .i_cfg_addr(ca), .i_cfg_be(cb), .i_cfg_wdata(cd),
      .o_cfg_ack(ack), .o_cfg_rdata(rdat), .i_gpi_level(gpi), .i_zoomed_video_enable0(zv0),
      .i_zoomed_video_enable1(zv1), .i_socket0_vcc(vcc0), .i_socket1_vcc(vcc1),
      .i_socket0_vpp(vpp0), .i_socket1_vpp(vpp1), .i_event_enable(en),
      .i_multifunction_terminal_event_sel(sel), .o_general_event_output(evt),
      .o_general_event_status(sts), .o_multifunction_terminal_event(term));
   initial begin
      forever #5 i_clock = ~i_clock;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic close_out();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : close_out
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic xfer(input logic wr, input logic fn, input logic [7:0] ad,
                       input logic [31:0] wd, input logic [31:0] e);
      seed = lfsr(seed);
      q.push_back(e);
      i_pmgpe_host_model.cfg(wr, fn, ad, 4'h3, wd, int'(seed[1:0]));
   endtask : xfer
   // Bit set by an event, zero-write keeps it, one-write clears it
   task automatic ev(input logic [15:0] e);
      int n;
      for (n = 0; n < 10 && sts === 16'h0000; n++) @(negedge i_clock);
      if (n == 10) chk("event latency", 1'b1, 1'b0);
      chk("status", {16'h0, e}, {16'h0, sts});
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, {16'h0, e});
      xfer(1'b1, 1'b0, 8'ha8, {16'h0, ~e}, 32'h0);
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, {16'h0, e});
      xfer(1'b1, 1'b0, 8'ha8, {16'h0, e}, 32'h0);
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, 32'h0);
   endtask : ev
   always @(negedge i_clock) begin
      if (ack === 1'b1) begin
         if (q.size() == 0) chk("stray ack", 1'b0, 1'b1);
         else chk("read data", q.pop_front(), rdat);
      end
   end
   initial begin
      repeat (20000) @(posedge i_clock);
      miscompares++;
      close_out();
   end
   initial begin
      logic [4:0] nv;
      repeat (16) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (5) @(posedge i_clock);
      xfer(1'b0, 1'b0, 8'ha6, 32'h0, 32'h0080_0000);
      xfer(1'b0, 1'b1, 8'ha7, 32'h0, 32'h0080_0000);
      xfer(1'b1, 1'b0, 8'ha4, 32'hffff_ffff, 32'h0);
      xfer(1'b0, 1'b0, 8'ha4, 32'h0, 32'h0080_0000);
      xfer(1'b1, 1'b0, 8'ha8, 32'hffff_ffff, 32'h0);
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, 32'h0);
      xfer(1'b0, 1'b0, 8'h40, 32'h0, 32'h0);
      for (int k = 0; k < 6; k++) begin
         seed = lfsr(seed);
         nv = (seed[4:0] == gpi) ? ~gpi : seed[4:0];
         @(posedge i_clock) gpi <= nv;
         ev({11'h0, nv ^ gpi});
      end
      @(posedge i_clock) zv0 <= 1'b1;
      ev(16'h8000);
      @(posedge i_clock) zv1 <= 1'b1;
      ev(16'h4000);
      @(posedge i_clock) vcc0 <= 2'h1;
      ev(16'h0800);
      @(posedge i_clock) vpp1 <= 2'h2;
      ev(16'h0900);
      @(posedge i_clock) vpp1 <= 2'h1;
      ev(16'h0900);
      @(posedge i_clock) vpp0 <= 2'h3;
      ev(16'h0800);
      @(posedge i_clock) vpp0 <= 2'h2;
      ev(16'h0900);
      @(posedge i_clock) vcc1 <= 2'h2;
      ev(16'h0800);
      // Terminal 1 toggles every cycle, so the clear meets a fresh edge
      fork
         begin
            repeat (12) @(posedge i_clock) gpi <= gpi ^ 5'h02;
         end
         begin
            repeat (6) @(posedge i_clock);
            xfer(1'b1, 1'b0, 8'ha8, 32'h0000_0002, 32'h0);
            @(negedge i_clock);
            chk("set wins", 1'b1, sts[1]);
         end
      join
      repeat (6) @(posedge i_clock);
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, 32'h0000_0002);
      xfer(1'b1, 1'b0, 8'ha8, 32'h0000_0002, 32'h0);
      xfer(1'b0, 1'b0, 8'ha8, 32'h0, 32'h0);
      en <= 16'h8000;
      sel <= 7'h05;
      zv0 <= 1'b0;
      repeat (4) @(negedge i_clock);
      chk("event", 1'b1, evt);
      chk("terminal", 7'h05, term);
      xfer(1'b1, 1'b0, 8'ha8, 32'h0, 32'h0);
      xfer(1'b0, 1'b1, 8'ha8, 32'h0, 32'h0);
      xfer(1'b1, 1'b1, 8'ha8, 32'h8000, 32'h0);
      @(posedge i_clock) sel <= 7'h00;
      @(negedge i_clock);
      chk("event held", 1'b1, evt);
      chk("terminal off", 7'h00, term);
      xfer(1'b1, 1'b0, 8'ha8, 32'h8000, 32'h0);
      @(negedge i_clock);
      chk("event cleared", 1'b0, evt);
      for (int n = 0; n < 20 && q.size() > 0; n++) @(posedge i_clock);
      if (q.size() > 0) chk("missing ack", 1'b1, 1'b0);
      close_out();
   end
endmodule : pmgpe_regs_top_bench
`default_nettype wire
